//--- rtl/bmc_pkg.sv
// Purpose: Shared constants and carriers for the basic mode control register.
// Assumes: 16-bit management register at address zero.
// Notes:   Field positions and reset values are named once here.
package bmc_pkg;
  localparam logic [4:0]  BMC_ADDR          = 5'h00;
  localparam int          BMC_BIT_RESET     = 15;
  localparam int          BMC_BIT_LOOPBACK  = 14;
  localparam int          BMC_BIT_SPEED     = 13;
  localparam int          BMC_BIT_AUTONEG   = 12;
  localparam int          BMC_BIT_PWRDN     = 11;
  localparam int          BMC_BIT_ISOLATE   = 10;
  localparam int          BMC_BIT_RESTART   = 9;
  localparam int          BMC_BIT_DUPLEX    = 8;
  localparam int          BMC_BIT_COLTEST   = 7;
  localparam logic [15:0] BMC_RW_MASK       = 16'hFF80;
  localparam logic        BMC_LOOPBACK_RST  = 1'b0;
  localparam logic        BMC_PWRDN_RST     = 1'b0;
  localparam logic        BMC_ISOLATE_RST   = 1'b0;
  // Software reset duration in nanoseconds and in clock cycles at 100 ns.
  localparam int          BMC_SWRST_NS      = 1000;
  localparam int          BMC_CLK_NS        = 100;
  localparam int          BMC_SWRST_CYC     = (BMC_SWRST_NS + BMC_CLK_NS - 1) / BMC_CLK_NS;

  // Management access request.
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } bmc_req_t;

  // Strap values caught at reset.
  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
  } bmc_strap_t;

  // Effective operating mode.
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
    logic power_down;
    logic isolate;
    logic loopback;
  } bmc_mode_t;
endpackage

//--- rtl/bmc_ctrl.sv
// Purpose: Basic mode control register of a 10/100 transceiver with its side effects.
// Assumes: Management accesses arrive as single-cycle strobes on core_clk.
// Notes:   Straps and the power down pin are asynchronous and are synchronised.
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl #(
  parameter int SWRST_CYC = bmc_pkg::BMC_SWRST_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire bmc_pkg::bmc_req_t   mgmt_req,
  output logic [15:0]              mgmt_rdata,
  input  wire bmc_pkg::bmc_strap_t strap_pins,
  input  wire logic                power_down_request_pin_n,
  input  wire logic                an_speed_100,
  input  wire logic                an_full_duplex,
  input  wire logic [3:0]          mii_txd,
  input  wire logic                mii_tx_en,
  input  wire logic [3:0]          line_rxd,
  input  wire logic                line_rx_dv,
  output logic [3:0]               mii_rxd,
  output logic                     mii_rx_dv,
  output logic                     mii_oe,
  output logic                     phy_core_reset,
  output bmc_pkg::bmc_mode_t       mode
);
  import bmc_pkg::*;

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [7:0]  swrst_cnt_reg;
  logic        swrst_busy_reg;
  logic        relatch_reg;
  bmc_strap_t  strap_meta_reg;
  bmc_strap_t  strap_sync_reg;
  logic        pd_meta_reg;
  logic        pd_sync_n_reg;
  logic        wr_hit;

  assign wr_hit = mgmt_req.wr_en && (mgmt_req.addr == BMC_ADDR);

  // Two-stage synchronisers for straps and the power down pin.
  always_ff @(posedge core_clk) begin
    strap_meta_reg <= strap_pins;
    strap_sync_reg <= strap_meta_reg;
    pd_meta_reg    <= power_down_request_pin_n;
    pd_sync_n_reg  <= pd_meta_reg;
  end

  // Software reset sequencer; a write of 1 starts it at once.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      swrst_busy_reg <= 1'b0;
      swrst_cnt_reg  <= 8'h00;
      relatch_reg    <= 1'b1;
    end else if (wr_hit && mgmt_req.wdata[BMC_BIT_RESET]) begin
      swrst_busy_reg <= 1'b1;
      swrst_cnt_reg  <= 8'(SWRST_CYC);
      relatch_reg    <= 1'b0;
    end else if (swrst_busy_reg) begin
      if (swrst_cnt_reg <= 8'h01) begin
        swrst_busy_reg <= 1'b0;
        relatch_reg    <= 1'b1;
      end
      swrst_cnt_reg <= swrst_cnt_reg - 8'h01;
    end else begin
      relatch_reg <= 1'b0;
    end
  end

  // Next value of the control word.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (relatch_reg) begin
      ctrl_next                   = 16'h0000;
      ctrl_next[BMC_BIT_LOOPBACK] = BMC_LOOPBACK_RST;
      ctrl_next[BMC_BIT_PWRDN]    = BMC_PWRDN_RST;
      ctrl_next[BMC_BIT_ISOLATE]  = BMC_ISOLATE_RST;
      ctrl_next[BMC_BIT_AUTONEG]  = strap_sync_reg.autoneg;
      ctrl_next[BMC_BIT_SPEED]    = strap_sync_reg.speed;
      ctrl_next[BMC_BIT_DUPLEX]   = strap_sync_reg.duplex;
    end else if (wr_hit && !swrst_busy_reg) begin
      ctrl_next = mgmt_req.wdata & BMC_RW_MASK;
    end
    ctrl_next[BMC_BIT_RESET]   = 1'b0;
    ctrl_next[BMC_BIT_RESTART] = 1'b0;
    if (!pd_sync_n_reg) begin
      ctrl_next[BMC_BIT_PWRDN] = 1'b1;
    end
  end

  // Control word storage; a hardware reset waits for relatch to load straps.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Read data, with the reset bit showing a reset in progress.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_req.rd_en) begin
      if (mgmt_req.addr == BMC_ADDR) begin
        mgmt_rdata                <= ctrl_reg;
        mgmt_rdata[BMC_BIT_RESET] <= swrst_busy_reg;
      end else begin
        mgmt_rdata <= 16'h0000;
      end
    end
  end

  // Effective mode; auto-negotiation results override manual bits.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode <= '0;
    end else begin
      mode.autoneg_en <= ctrl_reg[BMC_BIT_AUTONEG];
      if (ctrl_reg[BMC_BIT_AUTONEG]) begin
        mode.speed_100   <= an_speed_100;
        mode.full_duplex <= an_full_duplex;
      end else begin
        mode.speed_100   <= ctrl_reg[BMC_BIT_SPEED];
        mode.full_duplex <= ctrl_reg[BMC_BIT_DUPLEX];
      end
      mode.power_down <= ctrl_reg[BMC_BIT_PWRDN] | !pd_sync_n_reg;
      mode.isolate    <= ctrl_reg[BMC_BIT_ISOLATE];
      mode.loopback   <= ctrl_reg[BMC_BIT_LOOPBACK];
    end
  end

  // Core reset held during a software reset sequence.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phy_core_reset <= 1'b1;
    end else begin
      phy_core_reset <= swrst_busy_reg;
    end
  end

  // Receive path: loopback takes transmit nibbles; isolate releases MII.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mii_rxd   <= 4'h0;
      mii_rx_dv <= 1'b0;
      mii_oe    <= 1'b1;
    end else begin
      mii_oe <= ~ctrl_reg[BMC_BIT_ISOLATE];
      if (ctrl_reg[BMC_BIT_LOOPBACK]) begin
        mii_rxd   <= mii_txd;
        mii_rx_dv <= mii_tx_en;
      end else begin
        mii_rxd   <= line_rxd;
        mii_rx_dv <= line_rx_dv;
      end
    end
  end

  // Assertions.
  sequence s_swrst_start;
    wr_hit && mgmt_req.wdata[BMC_BIT_RESET];
  endsequence

  property p_swrst_busy;
    @(posedge core_clk) disable iff (reset)
      s_swrst_start |=> swrst_busy_reg;
  endproperty
  a_swrst_busy: assert property (p_swrst_busy) else $error("Reset did not start.");

  property p_swrst_ends;
    @(posedge core_clk) disable iff (reset)
      $rose(swrst_busy_reg) |-> ##[1:300] !swrst_busy_reg;
  endproperty
  a_swrst_ends: assert property (p_swrst_ends) else $error("Reset never cleared.");

  property p_rd_busy;
    @(posedge core_clk) disable iff (reset)
      (mgmt_req.rd_en && mgmt_req.addr == BMC_ADDR && swrst_busy_reg)
        |=> mgmt_rdata[BMC_BIT_RESET];
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("Reset bit read 0 while busy.");

  property p_relatch;
    @(posedge core_clk) disable iff (reset)
      $fell(swrst_busy_reg) |=> ctrl_reg[BMC_BIT_AUTONEG] == $past(strap_sync_reg.autoneg);
  endproperty
  a_relatch: assert property (p_relatch) else $error("Straps not relatched.");

  property p_loop;
    @(posedge core_clk) disable iff (reset)
      ctrl_reg[BMC_BIT_LOOPBACK] |=> mii_rxd == $past(mii_txd);
  endproperty
  a_loop: assert property (p_loop) else $error("Loopback data wrong.");

  property p_manual;
    @(posedge core_clk) disable iff (reset)
      !ctrl_reg[BMC_BIT_AUTONEG] |=> mode.speed_100 == $past(ctrl_reg[BMC_BIT_SPEED])
        && mode.full_duplex == $past(ctrl_reg[BMC_BIT_DUPLEX]);
  endproperty
  a_manual: assert property (p_manual) else $error("Manual mode wrong.");

  property p_auto;
    @(posedge core_clk) disable iff (reset)
      ctrl_reg[BMC_BIT_AUTONEG] |=> mode.speed_100 == $past(an_speed_100);
  endproperty
  a_auto: assert property (p_auto) else $error("Manual bits not ignored.");

  property p_pd_or;
    @(posedge core_clk) disable iff (reset)
      (ctrl_reg[BMC_BIT_PWRDN] || !pd_sync_n_reg) |=> mode.power_down;
  endproperty
  a_pd_or: assert property (p_pd_or) else $error("Power down not ORed.");

  property p_pin_sets;
    @(posedge core_clk) disable iff (reset)
      !pd_sync_n_reg |=> ctrl_reg[BMC_BIT_PWRDN];
  endproperty
  a_pin_sets: assert property (p_pin_sets) else $error("Pin did not set bit.");

  property p_isolate;
    @(posedge core_clk) disable iff (reset)
      ctrl_reg[BMC_BIT_ISOLATE] |=> !mii_oe;
  endproperty
  a_isolate: assert property (p_isolate) else $error("Isolate did not cut MII.");

  property p_rst_vals;
    @(posedge core_clk) disable iff (reset)
      $fell(relatch_reg) |-> !ctrl_reg[BMC_BIT_LOOPBACK] && !ctrl_reg[BMC_BIT_ISOLATE];
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("Reset values wrong.");

  // Writes that arrive during a software reset are dropped, so the word must not move.
  sequence s_busy_write;
    wr_hit && swrst_busy_reg && pd_sync_n_reg;
  endsequence

  property p_busy_drop;
    @(posedge core_clk) disable iff (reset)
      s_busy_write |=> $stable(ctrl_reg);
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("Write taken during reset.");

  property p_core_rst;
    @(posedge core_clk) disable iff (reset)
      swrst_busy_reg |=> phy_core_reset;
  endproperty
  a_core_rst: assert property (p_core_rst) else $error("Core not held in reset.");

  property p_idle_read;
    @(posedge core_clk) disable iff (reset)
      (mgmt_req.rd_en && mgmt_req.addr == BMC_ADDR && !swrst_busy_reg)
        |=> !mgmt_rdata[BMC_BIT_RESET];
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("Reset bit read 1 while idle.");

  property p_rsvd_zero;
    @(posedge core_clk) disable iff (reset)
      mgmt_req.rd_en |=> mgmt_rdata[BMC_BIT_COLTEST-1:0] == 7'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits not zero.");

  // A plain write lands in the writable bits 15 to 7; the self-clearing bits 15 and 9 are stored as 0 in ctrl_reg.
  property p_word_write;
    @(posedge core_clk) disable iff (reset)
      (wr_hit && !swrst_busy_reg && !relatch_reg && pd_sync_n_reg)
        |=> ctrl_reg == ($past(mgmt_req.wdata) & BMC_RW_MASK & 16'h7DFF);
  endproperty
  a_word_write: assert property (p_word_write) else $error("Word write lost.");

  property p_auto_duplex;
    @(posedge core_clk) disable iff (reset)
      ctrl_reg[BMC_BIT_AUTONEG]
        |=> mode.full_duplex == $past(an_full_duplex) && mode.autoneg_en;
  endproperty
  a_auto_duplex: assert property (p_auto_duplex) else $error("Manual duplex not ignored.");

  property p_loop_dv;
    @(posedge core_clk) disable iff (reset)
      ctrl_reg[BMC_BIT_LOOPBACK] |=> mii_rx_dv == $past(mii_tx_en);
  endproperty
  a_loop_dv: assert property (p_loop_dv) else $error("Loopback valid wrong.");

  property p_pd_off;
    @(posedge core_clk) disable iff (reset)
      (!ctrl_reg[BMC_BIT_PWRDN] && pd_sync_n_reg) |=> !mode.power_down;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Power down without request.");

  property p_relatch_mode;
    @(posedge core_clk) disable iff (reset)
      $fell(swrst_busy_reg) |=> ctrl_reg[BMC_BIT_SPEED] == $past(strap_sync_reg.speed)
        && ctrl_reg[BMC_BIT_DUPLEX] == $past(strap_sync_reg.duplex);
  endproperty
  a_relatch_mode: assert property (p_relatch_mode) else $error("Mode straps not relatched.");
endmodule
`default_nettype wire

//--- tb/bmc_mii_src.sv
// Purpose: Model of the MAC transmit and line receive nibble sources.
// Assumes: Both streams change on every rising edge.
// Notes:   Line data is the inverse of transmit data and line valid is low, so a wrong source shows.
`timescale 1ns/1ps
`default_nettype none
module bmc_mii_src (
  input  wire logic     core_clk,
  output var  logic [3:0] mii_txd,
  output var  logic       mii_tx_en,
  output var  logic [3:0] line_rxd,
  output var  logic       line_rx_dv
);
  // Start both streams at known values.
  initial begin
    mii_txd    = 4'h0;
    line_rxd   = 4'hF;
    mii_tx_en  = 1'b1;
    line_rx_dv = 1'b0;
  end
  // A counter moves every cycle so stale data never matches.
  always @(posedge core_clk) begin
    mii_txd  <= mii_txd + 4'h1;
    line_rxd <= ~(mii_txd + 4'h1);
  end
endmodule
`default_nettype wire

//--- tb/tb_bmc_ctrl.sv
// Purpose: Self-checking bench for the basic mode control register.
// Assumes: Software reset shortened to four cycles.
// Notes:   Management accesses are single-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_bmc_ctrl;
  import bmc_pkg::*;
  logic        core_clk;
  logic        reset;
  logic        power_down_request_pin_n;
  bmc_req_t    req;
  bmc_strap_t  straps;
  bmc_mode_t   mode;
  logic [15:0] rdata;
  logic [3:0]  mii_txd;
  logic [3:0]  line_rxd;
  logic [3:0]  mii_rxd;
  logic        mii_tx_en;
  logic        line_rx_dv;
  logic        mii_rx_dv;
  logic        mii_oe;
  logic        phy_core_reset;
  logic        an_speed;
  logic        an_duplex;
  int          errors;
  int          num_checks;
  // The design under test with a short software reset.
  bmc_ctrl #(.SWRST_CYC(4)) DUT (.core_clk(core_clk), .reset(reset), .mgmt_req(req),
    .mgmt_rdata(rdata), .strap_pins(straps),
    .power_down_request_pin_n(power_down_request_pin_n), .an_speed_100(an_speed),
    .an_full_duplex(an_duplex), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .line_rxd(line_rxd),
    .line_rx_dv(line_rx_dv), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_oe(mii_oe),
    .phy_core_reset(phy_core_reset), .mode(mode));
  // The nibble sources on the far side of the MII.
  bmc_mii_src src (.core_clk(core_clk), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en),
    .line_rxd(line_rxd), .line_rx_dv(line_rx_dv));
  // The clock toggles every half period of 50 ns.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One write strobe of a whole word.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk) req <= '0;
  endtask
  // One read strobe, then the registered data is compared.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk) req <= '0;
    #1 `CHK(rdata, e)
  endtask
  // Lets a number of edges pass and steps past the last one.
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    complete_run();
  end
  // Main sequence of register accesses and port checks.
  initial begin
    errors = 0;
    num_checks = 0;
    reset = 1'b1;
    req = '0;
    straps = '{1'b1, 1'b0, 1'b1};
    an_speed = 1'b1;
    an_duplex = 1'b0;
    power_down_request_pin_n = 1'b1;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    settle(3);
    rd(BMC_ADDR, 16'h1100);
    rd(5'h01, 16'h0000);
    wr(5'h01, 16'hFFFF);
    rd(BMC_ADDR, 16'h1100);
    wr(BMC_ADDR, 16'h2100);
    settle(3);
    `CHK(mode.speed_100, 1'b1)
    `CHK(mode.full_duplex, 1'b1)
    wr(BMC_ADDR, 16'h0000);
    settle(3);
    `CHK(mode.speed_100, 1'b0)
    `CHK(mode.full_duplex, 1'b0)
    wr(BMC_ADDR, 16'h1100);
    settle(3);
    `CHK({mode.speed_100, mode.full_duplex}, 2'b10)
    `CHK(mode.autoneg_en, 1'b1)
    @(posedge core_clk) begin
      an_speed  <= 1'b0;
      an_duplex <= 1'b1;
    end
    settle(3);
    `CHK({mode.speed_100, mode.full_duplex}, 2'b01)
    wr(BMC_ADDR, 16'h4000);
    settle(3);
    `CHK(mii_rxd, mii_txd - 4'h1)
    `CHK(mii_rx_dv, 1'b1)
    `CHK(mode.loopback, 1'b1)
    wr(BMC_ADDR, 16'h0000);
    settle(3);
    `CHK(mii_rxd, ~(mii_txd - 4'h1))
    `CHK(mii_rx_dv, 1'b0)
    `CHK(mode.loopback, 1'b0)
    wr(BMC_ADDR, 16'h0800);
    settle(3);
    `CHK(mode.power_down, 1'b1)
    wr(BMC_ADDR, 16'h0000);
    @(posedge core_clk) power_down_request_pin_n <= 1'b0;
    settle(5);
    `CHK(mode.power_down, 1'b1)
    rd(BMC_ADDR, 16'h0800);
    wr(BMC_ADDR, 16'h0000);
    rd(BMC_ADDR, 16'h0800);
    @(posedge core_clk) power_down_request_pin_n <= 1'b1;
    settle(4);
    wr(BMC_ADDR, 16'h0000);
    rd(BMC_ADDR, 16'h0000);
    `CHK(mode.power_down, 1'b0)
    wr(BMC_ADDR, 16'h0400);
    settle(3);
    `CHK(mii_oe, 1'b0)
    `CHK(mode.isolate, 1'b1)
    wr(BMC_ADDR, 16'h0000);
    settle(3);
    `CHK(mii_oe, 1'b1)
    @(posedge core_clk) straps <= '{1'b0, 1'b1, 1'b0};
    settle(4);
    wr(BMC_ADDR, 16'h8000);
    rd(BMC_ADDR, 16'h8000);
    `CHK(phy_core_reset, 1'b1)
    wr(BMC_ADDR, 16'h4400);
    settle(8);
    rd(BMC_ADDR, 16'h2000);
    `CHK(phy_core_reset, 1'b0)
    complete_run();
  end
endmodule
`default_nettype wire
